// ===== include/gct_pkg.sv
// Constants shared by the gated sixteen-bit timer and its helpers.
// Assumes a single 25 MHz system clock and byte addresses on AHB-Lite.
package gct_pkg;
    // System clock period in ns and instruction clock division
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned INSTR_DIV = 4;
    // Default watchdog base period in system clocks
    localparam int unsigned WDT_BASE_CYCLES = 1024;

    // Register byte offsets
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_GATE = 6'h04;
    localparam logic [5:0] OFF_CNT_LO = 6'h08;
    localparam logic [5:0] OFF_CNT_HI = 6'h0c;
    localparam logic [5:0] OFF_PLIM = 6'h10;
    localparam logic [5:0] OFF_WDT = 6'h14;
    localparam logic [5:0] OFF_SIB = 6'h18;

    // Control register fields
    localparam int unsigned CTL_SRC = 6;
    localparam int unsigned CTL_PS = 4;
    localparam int unsigned CTL_OSC = 3;
    localparam int unsigned CTL_SBYP = 2;
    localparam int unsigned CTL_ON = 0;
    localparam logic [7:0] CTL_MASK = 8'hfd;
    // Gate register fields
    localparam int unsigned GT_EN = 7;
    localparam int unsigned GT_POL = 6;
    localparam int unsigned GT_TOG = 5;
    localparam int unsigned GT_VAL = 2;
    localparam int unsigned GT_SS = 0;
    localparam logic [7:0] GT_MASK = 8'he3;
    // Watchdog config fields
    localparam int unsigned WD_RATE = 0;
    localparam int unsigned WD_ASSIGN = 3;
    localparam int unsigned WD_CLEAR = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] GATE_RST = 8'h00;
    localparam logic [7:0] PLIM_RST = 8'hff;
    localparam logic [3:0] WDT_RST = 4'h0;

    // Pin synchroniser lanes
    localparam int unsigned PIN_EXT = 0;
    localparam int unsigned PIN_XTAL = 1;
    localparam int unsigned PIN_CAP = 2;
    localparam int unsigned PIN_GATE = 3;
    localparam int unsigned PIN_N = 4;

    // Count source and gate source codes
    typedef enum logic [1:0] {
        GCT_SRC_INSTR = 2'h0,
        GCT_SRC_SYS = 2'h1,
        GCT_SRC_PIN = 2'h2,
        GCT_SRC_CAP = 2'h3
    } gct_src_t;
    typedef enum logic [1:0] {
        GCT_GS_PIN = 2'h0,
        GCT_GS_BYTE = 2'h1,
        GCT_GS_PERIOD = 2'h2,
        GCT_GS_WDT = 2'h3
    } gct_gsrc_t;
endpackage

// ===== include/gct_gate_if.sv
// Signals between the timer core and the sibling gate-source timers.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface gct_gate_if;
    logic instr_tick;
    logic byte_ovf;
    logic period_pulse;
    logic wdt_ovf;
    logic wdt_run;
    logic wdt_clear;
    logic ps_assign;
    logic [2:0] ps_rate;
    logic [7:0] period_limit;
    logic [7:0] byte_count;
    logic [7:0] period_count;
    modport core (input instr_tick, byte_ovf, period_pulse, wdt_ovf, byte_count, period_count,
                  output wdt_run, wdt_clear, ps_assign, ps_rate, period_limit);
    modport src (output instr_tick, byte_ovf, period_pulse, wdt_ovf, byte_count, period_count,
                 input wdt_run, wdt_clear, ps_assign, ps_rate, period_limit);
endinterface

// ===== rtl/gct_pin_sync.sv
// Three-flop synchronisers with agreement filter and edge pulses.
// Assumes asynchronous pin levels and one system clock.
`timescale 1ns/1ns
module gct_pin_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [gct_pkg::PIN_N-1:0] pin,
    output logic [gct_pkg::PIN_N-1:0] level,
    output logic [gct_pkg::PIN_N-1:0] rise,
    output logic [gct_pkg::PIN_N-1:0] fall
);
    logic [gct_pkg::PIN_N-1:0] s1;
    logic [gct_pkg::PIN_N-1:0] s2;
    logic [gct_pkg::PIN_N-1:0] s3;
    logic [gct_pkg::PIN_N-1:0] agree;
    logic [gct_pkg::PIN_N-1:0] next_level;

    // Level moves only where the second and third stages agree
    assign agree = ~(s2 ^ s3);
    assign next_level = (agree & s2) | (~agree & level);

    // Synchroniser chain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Filtered level and its edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= '0;
            rise <= '0;
            fall <= '0;
        end else if (ce) begin
            level <= next_level;
            rise <= next_level & ~level;
            fall <= ~next_level & level;
        end
    end
endmodule // gct_pin_sync

// ===== rtl/gct_gate_sources.sv
// Sibling timers that feed the gate: byte timer, period timer, watchdog.
// Assumes the core drives watchdog run and clear and the period limit.
`timescale 1ns/1ns
module gct_gate_sources #(
    parameter int unsigned WDT_BASE = gct_pkg::WDT_BASE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    gct_gate_if.src gi
);
    logic [1:0] div;
    logic [15:0] wdt_base;
    logic [7:0] wdt_post;
    logic [7:0] post_lim;
    logic base_end;

    // Watchdog post-divider limit from prescaler assignment and rate
    assign post_lim = gi.ps_assign ? 8'((9'h1 << gi.ps_rate) - 9'h1) : 8'h00;
    assign base_end = (wdt_base == 16'(WDT_BASE - 1));

    // Instruction tick, one system clock in four
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= 2'h0;
            gi.instr_tick <= 1'b0;
        end else if (ce) begin
            div <= div + 2'h1;
            gi.instr_tick <= (div == 2'(gct_pkg::INSTR_DIV - 1));
        end
    end

    // rollover gate pulse
    // Byte timer rolls from ff to 00 and pulses once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gi.byte_count <= 8'h00;
            gi.byte_ovf <= 1'b0;
        end else if (ce) begin
            gi.byte_ovf <= gi.instr_tick && (gi.byte_count == 8'hff);
            if (gi.instr_tick) begin
                gi.byte_count <= gi.byte_count + 8'h01;
            end
        end
    end

    // clear gives gate pulse
    // Period timer clears on the increment after a match and pulses on the same edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gi.period_count <= 8'h00;
            gi.period_pulse <= 1'b0;
        end else if (ce) begin
            gi.period_pulse <= gi.instr_tick && (gi.period_count == gi.period_limit);
            if (gi.instr_tick) begin
                gi.period_count <= (gi.period_count == gi.period_limit) ? 8'h00
                                   : gi.period_count + 8'h01;
            end
        end
    end

    // Watchdog counter; its overflow is only a gate pulse, never a reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_base <= 16'h0000;
            wdt_post <= 8'h00;
            gi.wdt_ovf <= 1'b0;
        end else if (ce) begin
            gi.wdt_ovf <= gi.wdt_run && !gi.wdt_clear && base_end && (wdt_post >= post_lim);
            if (!gi.wdt_run || gi.wdt_clear) begin
                wdt_base <= 16'h0000;
                wdt_post <= 8'h00;
            end else if (base_end) begin
                wdt_base <= 16'h0000;
                wdt_post <= (wdt_post >= post_lim) ? 8'h00 : wdt_post + 8'h01;
            end else begin
                wdt_base <= wdt_base + 16'h0001;
            end
        end
    end
endmodule // gct_gate_sources

// ===== rtl/gct_timer.sv
// Gated sixteen-bit timer with AHB-Lite register slave.
// Assumes one 25 MHz clock, an AHB-Lite master, and asynchronous pins.
// Contract
// - 16-bit counter, byte writes replace count
// - internal source advances each instruction cycle
// - on/gate-enable choose off, free or gated
// - source field and crystal bit pick clock
// - internal ticks divided by the prescaler
// - external rising edges advance the count
// - external input synchronised or used unsynchronised; bypass here only skips the alignment stage
// - falling edge needed before first counted rise
// - gate active counts, inactive holds count
// - gate polarity bit; gating only when enabled
// - gate source: pin, byte, period, watchdog
// - byte timer rollover gives one gate pulse
// - period timer clear gives one gate pulse
// - watchdog runs when gated by it
// - watchdog interval from prescaler assign and rate
// - watchdog gating never resets or wakes
// - watchdog clears and wake restart the interval; no wake input here, clears only
// - prescale ratios 1, 2, 4, 8
// - sync bit used for external sources only
// - counter off clears gate toggle flip-flop
`timescale 1ns/1ns
module gct_timer #(
    parameter int unsigned WDT_BASE = gct_pkg::WDT_BASE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_count_clock_pin,
    input wire logic crystal_osc_pins,
    input wire logic cap_sense_osc,
    input wire logic gate_input,
    input wire logic watchdog_clear_instr,
    output logic count_wrap,
    output logic gate_level,
    output logic crystal_osc_run,
    output logic wdt_running
);
    gct_gate_if gi ();
    logic [gct_pkg::PIN_N-1:0] pin_lvl;
    logic [gct_pkg::PIN_N-1:0] pin_rise;
    logic [gct_pkg::PIN_N-1:0] pin_fall;
    logic [7:0] ctrl;
    logic [7:0] gate;
    logic [7:0] plim;
    logic [3:0] wdcfg;
    logic [15:0] count;
    logic [2:0] psc;
    logic [5:0] wr_addr;
    logic wr_pend;
    logic take;
    logic [31:0] rd_mux;
    logic wr_ctrl, wr_gate, wr_lo, wr_hi, wr_wdt;
    logic cnt_wr;
    logic need_fall;
    logic sel_rise, sel_fall, rise_d, fall_d, ext_rise, ext_fall;
    logic raw_tick, cnt_en, psc_hit, adv;
    logic g_raw, g_act, g_act_d, tog_ff, gate_active;
    gct_pkg::gct_src_t src;
    gct_pkg::gct_gsrc_t gss;

    // Prescaler mask for ratio 1:1, 1:2, 1:4 or 1:8
    function automatic logic [2:0] ps_mask(input logic [1:0] ps);
        ps_mask = 3'((4'h1 << ps) - 4'h1);
    endfunction

    assign src = gct_pkg::gct_src_t'(ctrl[gct_pkg::CTL_SRC +: 2]);
    assign gss = gct_pkg::gct_gsrc_t'(gate[gct_pkg::GT_SS +: 2]);

    gct_pin_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin({gate_input, cap_sense_osc, crystal_osc_pins, ext_count_clock_pin}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    gct_gate_sources #(.WDT_BASE(WDT_BASE)) u_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .gi(gi.src)
    );

    // AHB-Lite address phase decode
    assign take = hsel && htrans[1] && hready;
    assign wr_ctrl = wr_pend && (wr_addr == gct_pkg::OFF_CTRL);
    assign wr_gate = wr_pend && (wr_addr == gct_pkg::OFF_GATE);
    assign wr_lo = wr_pend && (wr_addr == gct_pkg::OFF_CNT_LO);
    assign wr_hi = wr_pend && (wr_addr == gct_pkg::OFF_CNT_HI);
    assign wr_wdt = wr_pend && (wr_addr == gct_pkg::OFF_WDT);
    assign cnt_wr = wr_lo || wr_hi;

    // Read data selection; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[5:0])
            gct_pkg::OFF_CTRL: rd_mux = {24'h0, ctrl};
            gct_pkg::OFF_GATE: rd_mux = {24'h0, gate[7:3], gate_active, gate[1:0]};
            gct_pkg::OFF_CNT_LO: rd_mux = {24'h0, count[7:0]};
            gct_pkg::OFF_CNT_HI: rd_mux = {24'h0, count[15:8]};
            gct_pkg::OFF_PLIM: rd_mux = {24'h0, plim};
            gct_pkg::OFF_WDT: rd_mux = {28'h0, wdcfg};
            gct_pkg::OFF_SIB: rd_mux = {16'h0, gi.period_count, gi.byte_count};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 6'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_pend <= take && hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take) begin
                wr_addr <= haddr[5:0];
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Control, gate and watchdog configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= gct_pkg::CTRL_RST;
            gate <= gct_pkg::GATE_RST;
            plim <= gct_pkg::PLIM_RST;
            wdcfg <= gct_pkg::WDT_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= hwdata[7:0] & gct_pkg::CTL_MASK;
            end
            if (wr_gate) begin
                gate <= hwdata[7:0] & gct_pkg::GT_MASK;
            end
            if (wr_pend && (wr_addr == gct_pkg::OFF_PLIM)) begin
                plim <= hwdata[7:0];
            end
            if (wr_wdt) begin
                wdcfg <= hwdata[3:0];
            end
        end
    end

    // pick pin or crystal by oscillator bit
    assign sel_rise = (src == gct_pkg::GCT_SRC_CAP) ? pin_rise[gct_pkg::PIN_CAP]
                    : ctrl[gct_pkg::CTL_OSC] ? pin_rise[gct_pkg::PIN_XTAL]
                    : pin_rise[gct_pkg::PIN_EXT];
    assign sel_fall = (src == gct_pkg::GCT_SRC_CAP) ? pin_fall[gct_pkg::PIN_CAP]
                    : ctrl[gct_pkg::CTL_OSC] ? pin_fall[gct_pkg::PIN_XTAL]
                    : pin_fall[gct_pkg::PIN_EXT];
    // synchronised path adds one system-clock alignment stage
    // bypass bit only matters for external sources
    assign ext_rise = ctrl[gct_pkg::CTL_SBYP] ? sel_rise : rise_d;
    assign ext_fall = ctrl[gct_pkg::CTL_SBYP] ? sel_fall : fall_d;

    // Alignment stage for synchronised external edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_d <= 1'b0;
            fall_d <= 1'b0;
        end else if (ce) begin
            rise_d <= sel_rise;
            fall_d <= sel_fall;
        end
    end

    // instruction tick or every system clock or external edge
    // external rise counts only once a fall was seen
    always_comb begin
        case (src)
            gct_pkg::GCT_SRC_INSTR: raw_tick = gi.instr_tick;
            gct_pkg::GCT_SRC_SYS: raw_tick = 1'b1;
            default: raw_tick = ext_rise && !need_fall;
        endcase
    end

    // arm after off, reset or count write; fall disarms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            need_fall <= 1'b1;
        end else if (ce) begin
            if (!ctrl[gct_pkg::CTL_ON] || cnt_wr) begin
                need_fall <= 1'b1;
            end else if (ext_fall) begin
                need_fall <= 1'b0;
            end
        end
    end

    always_comb begin
        case (gss)
            gct_pkg::GCT_GS_PIN: g_raw = pin_lvl[gct_pkg::PIN_GATE];
            gct_pkg::GCT_GS_BYTE: g_raw = gi.byte_ovf;
            gct_pkg::GCT_GS_PERIOD: g_raw = gi.period_pulse;
            default: g_raw = gi.wdt_ovf;
        endcase
    end
    // polarity 0 active low, 1 active high
    assign g_act = gate[gct_pkg::GT_POL] ? g_raw : !g_raw;
    assign gate_active = gate[gct_pkg::GT_TOG] ? tog_ff : g_act;

    // Gate toggle flip-flop flips on each rising active edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            g_act_d <= 1'b0;
            tog_ff <= 1'b0;
        end else if (ce) begin
            g_act_d <= g_act;
            if (!ctrl[gct_pkg::CTL_ON]) begin
                tog_ff <= 1'b0;
            end else if (g_act && !g_act_d) begin
                tog_ff <= !tog_ff;
            end
        end
    end

    // off, free running, or gate controlled
    assign cnt_en = ctrl[gct_pkg::CTL_ON] && (!gate[gct_pkg::GT_EN] || gate_active);
    // ratio chosen by the prescale field
    assign psc_hit = ((psc & ps_mask(ctrl[gct_pkg::CTL_PS +: 2]))
                     == ps_mask(ctrl[gct_pkg::CTL_PS +: 2]));
    assign adv = cnt_en && raw_tick && psc_hit && !cnt_wr;

    // Prescaler counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc <= 3'h0;
        end else if (ce) begin
            if (cnt_wr) begin
                psc <= 3'h0;
            end else if (cnt_en && raw_tick) begin
                psc <= psc_hit ? 3'h0 : psc + 3'h1;
            end
        end
    end

    // byte writes replace half of the running count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 16'h0000;
            count_wrap <= 1'b0;
        end else if (ce) begin
            count_wrap <= adv && (count == 16'hffff);
            if (wr_lo) begin
                count[7:0] <= hwdata[7:0];
            end else if (wr_hi) begin
                count[15:8] <= hwdata[7:0];
            end else if (adv) begin
                count <= count + 16'h0001;
            end
        end
    end

    // watchdog runs for its gate, regardless of counter on
    // interval from prescaler assign and rate
    // no watchdog reset or wake is produced here
    // clear instructions and WD_CLEAR writes restart the watchdog
    assign gi.period_limit = plim;
    assign gi.ps_assign = wdcfg[gct_pkg::WD_ASSIGN];
    assign gi.ps_rate = wdcfg[gct_pkg::WD_RATE +: 3];
    assign gi.wdt_run = wdt_running;
    assign gi.wdt_clear = watchdog_clear_instr || (wr_wdt && hwdata[gct_pkg::WD_CLEAR]);

    // Registered status outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_level <= 1'b0;
            crystal_osc_run <= 1'b0;
            wdt_running <= 1'b0;
        end else if (ce) begin
            gate_level <= gate_active;
            crystal_osc_run <= ctrl[gct_pkg::CTL_OSC];
            wdt_running <= gate[gct_pkg::GT_EN] && (gss == gct_pkg::GCT_GS_WDT);
        end
    end

    // Quiet-run counter for the prescaler check
    logic [3:0] quiet;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= 4'h0;
        end else if (!ce || wr_pend) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    off_hold_a: assert property (ce && !ctrl[0] && !cnt_wr |=> $stable(count))
        else $error("count moved while counter off");
    gate_hold_a: assert property (ce && gate[7] && !gate_active && !cnt_wr |=> $stable(count))
        else $error("count moved while gate inactive");
    wrap_zero_a: assert property (ce && adv && count == 16'hffff |=> count == 16'h0000)
        else $error("all-ones count did not wrap");
    tog_clear_a: assert property (ce && !ctrl[0] |=> !tog_ff)
        else $error("toggle flip-flop not cleared");
    arm_write_a: assert property (ce && cnt_wr |=> need_fall)
        else $error("count write did not arm falling edge");
    sys_step_a: assert property (ce && ctrl == 8'h41 && !gate[7] && !cnt_wr
                                 |=> count == $past(count) + 16'h0001)
        else $error("system clock did not step count");
    ratio_eight_a: assert property (quiet >= 4'h9 && ctrl == 8'h71 && !gate[7]
                                    |-> count == $past(count, 8) + 16'h0001)
        else $error("1:8 prescale wrong over eight clocks");
    wdt_run_a: assert property (ce && gate[7] && gate[1:0] == 2'h3 |=> wdt_running)
        else $error("watchdog not started for gate");
    ext_arm_a: assert property (src[1] && need_fall |-> !adv)
        else $error("external rise counted before fall");

    wrap_c: cover property (count_wrap);
    toggle_c: cover property (gate[5] && tog_ff);
    wdt_gate_c: cover property (wdt_running && gi.wdt_ovf);
    ext_count_c: cover property (src[1] && adv);
endmodule // gct_timer

// ===== verification/gct_ext_src_model.sv
// Model of the external count clock feeding the timer's pins.
// Assumes the bench raises go for one clock with the pulse count set.
`timescale 1ns/1ns
module gct_ext_src_model (
    input wire logic hclk,
    input wire logic go,
    input wire logic [3:0] n,
    output logic pin,
    output logic busy
);
    logic [7:0] ph = 8'h00;
    // n pulses, 8 clocks high then 8 low; low and still when idle
    always_ff @(posedge hclk) begin
        if (go) begin
            ph <= {n, 4'h0};
        end else if (busy) begin
            ph <= ph - 8'h01;
        end
    end
    assign busy = (ph != 8'h00);
    assign pin = busy & ph[3];
endmodule // gct_ext_src_model

// ===== verification/gated_sixteen_bit_timer_tb_top.sv
// Self-checking bench for the gated timer over AHB-Lite.
// Assumes zero-wait slave, registers in bits 7:0, clock pin model.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module gated_sixteen_bit_timer_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, gate_input = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, count_wrap, gate_level, osc_run, wdt_running, go = 1'b0;
    logic pin, busy, seen;
    logic [3:0] n = 4'h4;
    logic [15:0] v;
    int bad_count = 0, checked = 0, s;
    gct_timer #(.WDT_BASE(8)) uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_count_clock_pin(pin), .crystal_osc_pins(1'b0),
        .cap_sense_osc(pin), .gate_input(gate_input), .watchdog_clear_instr(1'b0),
        .count_wrap(count_wrap), .gate_level(gate_level), .crystal_osc_run(osc_run),
        .wdt_running(wdt_running));
    gct_ext_src_model model (.hclk(hclk), .go(go), .n(n), .pin(pin), .busy(busy));
    // Clock generator
    initial begin
        forever #20 hclk = ~hclk;
    end
    // Single AHB-Lite transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {26'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Read both count bytes with the counter stopped
    task automatic rd_cnt();
        bus(1'b0, gct_pkg::OFF_CNT_LO, 8'h00);
        v[7:0] = r[7:0];
        bus(1'b0, gct_pkg::OFF_CNT_HI, 8'h00);
        v[15:8] = r[7:0];
    endtask
    // Clear count, run with control value c for 64 clocks, stop, read back
    task automatic run(input logic [7:0] c);
        bus(1'b1, gct_pkg::OFF_CNT_LO, 8'h00);
        bus(1'b1, gct_pkg::OFF_CNT_HI, 8'h00);
        bus(1'b1, gct_pkg::OFF_CTRL, c);
        repeat (64) @(posedge hclk);
        bus(1'b1, gct_pkg::OFF_CTRL, c & 8'hfe);
        rd_cnt();
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, gct_pkg::OFF_PLIM, 8'h00);
        `CHK(r, 32'h000000ff)
        // Short period early, while the period timer is still below it
        bus(1'b1, gct_pkg::OFF_PLIM, 8'h03);
        bus(1'b0, 6'h3c, 8'h00);
        `CHK(r, 32'h0)
        bus(1'b1, gct_pkg::OFF_CNT_LO, 8'h34);
        bus(1'b1, gct_pkg::OFF_CNT_HI, 8'h12);
        rd_cnt();
        `CHK(v, 16'h1234)
        // Crystal bit readback and status; bit 1 always reads zero
        bus(1'b1, gct_pkg::OFF_CTRL, 8'h0a);
        bus(1'b0, gct_pkg::OFF_CTRL, 8'h00);
        `CHK(r, 32'h00000008)
        `CHK(osc_run, 1'b1)
        `CHK(hresp, 1'b0)
        $display("test registers done");
        run(8'h40);
        `CHK(v, 16'h0000)
        for (s = 0; s < 4; s++) begin
            run(8'h41 | 8'(s << 4));
            `CHK((v >= 16'(64 >> s)) && (v <= 16'((68 >> s) + 1)), 1'b1)
        end
        run(8'h01);
        `CHK((v >= 16'd15) && (v <= 16'd18), 1'b1)
        $display("test internal done");
        bus(1'b1, gct_pkg::OFF_CNT_LO, 8'hf0);
        bus(1'b1, gct_pkg::OFF_CNT_HI, 8'hff);
        bus(1'b1, gct_pkg::OFF_CTRL, 8'h41);
        seen = 1'b0;
        repeat (40) @(posedge hclk) seen |= count_wrap;
        bus(1'b1, gct_pkg::OFF_CTRL, 8'h40);
        rd_cnt();
        `CHK(seen, 1'b1)
        `CHK(v < 16'h0040, 1'b1)
        $display("test wrap done");
        for (s = 0; s < 3; s++) begin
            bus(1'b1, gct_pkg::OFF_CNT_LO, 8'h00);
            bus(1'b1, gct_pkg::OFF_CTRL, s == 2 ? 8'hc1 : 8'h81 | 8'(s << 2));
            @(posedge hclk) go <= 1'b1;
            @(posedge hclk) go <= 1'b0;
            // Model loads its count at this edge, so look from the next one on
            do @(posedge hclk); while (busy !== 1'b0);
            repeat (12) @(posedge hclk);
            bus(1'b1, gct_pkg::OFF_CTRL, 8'h80);
            rd_cnt();
            `CHK(v, 16'h0003)
        end
        $display("test external done");
        gate_input <= 1'b1;
        bus(1'b1, gct_pkg::OFF_GATE, 8'h80);
        run(8'h41);
        `CHK(v, 16'h0000)
        `CHK(gate_level, 1'b0)
        bus(1'b1, gct_pkg::OFF_GATE, 8'hc0);
        run(8'h41);
        `CHK(v >= 16'd64, 1'b1)
        `CHK(gate_level, 1'b1)
        // Period pulse every 16 clocks gates one system-clock count each
        bus(1'b1, gct_pkg::OFF_GATE, 8'hc2);
        run(8'h41);
        `CHK((v >= 16'd4) && (v <= 16'd5), 1'b1)
        // Watchdog gate in toggle mode, prescaler left untouched
        bus(1'b1, gct_pkg::OFF_GATE, 8'ha3);
        repeat (2) @(posedge hclk);
        `CHK(wdt_running, 1'b1)
        bus(1'b1, gct_pkg::OFF_GATE, 8'h03);
        repeat (2) @(posedge hclk);
        `CHK(wdt_running, 1'b0)
        $display("test gate done");
        summarize();
    end
endmodule // gated_sixteen_bit_timer_tb_top
